// File: rtl/qig_pkg.sv
package qig_pkg;

  // register map, byte addresses, one aligned word each
  localparam logic [4:0]  OFS_CDD      = 5'h00;  // clock domain disable
  localparam logic [4:0]  OFS_PATH     = 5'h04;  // input path select
  localparam logic [4:0]  OFS_MUX      = 5'h08;  // phase error source select
  localparam logic [4:0]  OFS_STAT     = 5'h0c;  // sticky event status
  localparam logic [4:0]  OFS_MASK     = 5'h10;  // interrupt mask
  localparam logic [4:0]  OFS_LIVE     = 5'h14;  // live state, read only

  // field positions
  localparam int unsigned CDD_ENC_BIT   = 9;     // encoder clock domain off
  localparam int unsigned PATH_LANE_W   = 8;     // one byte lane per input
  localparam int unsigned PATH_SYNC_OFS = 0;     // sync-only select in lane
  localparam int unsigned PATH_FILT_OFS = 1;     // sync+filter select in lane
  localparam int unsigned MUX_SEL_BIT   = 0;     // 0 picks encoder 0
  localparam int unsigned LIVE_ERR_OFS  = 0;     // live phase errors
  localparam int unsigned LIVE_IN_OFS   = 2;     // conditioned inputs
  localparam int unsigned LIVE_CLK_BIT  = 10;    // encoder clock running

  // writable bits
  localparam logic [31:0] CDD_WMASK    = 32'h0000_0200;
  localparam logic [31:0] PATH_WMASK   = 32'h0303_0303;

  // reset values
  localparam logic [31:0] RST_CDD      = 32'h0000_0000;  // encoder clock on
  localparam logic [31:0] RST_PATH     = 32'h0101_0101;  // all sync-only
  localparam logic        RST_MUX      = 1'b0;
  localparam logic [1:0]  RST_MASK     = 2'h0;

  // sizes
  localparam int unsigned NUM_ENC      = 2;     // encoder modules
  localparam int unsigned NUM_IN       = 4;     // a, b, index, strobe

  // filter: samples that must agree before the output follows
  localparam logic [2:0]  FILT_LEN     = 3'h3;

endpackage : qig_pkg

// File: rtl/qig_in_cond.sv
`timescale 1ns/1ps
`default_nettype none

// one encoder input: two-flop synchroniser, then optional filter
module qig_in_cond
  import qig_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic pin,       // raw pin, asynchronous
  input  wire logic run,       // encoder clock domain running
  input  wire logic sel_sync,  // sync-only path requested
  input  wire logic sel_filt,  // sync+filter path requested
  output var  logic cond_out   // level handed to the encoder
);
  import qig_pkg::*;

  logic       s1_reg;    // first sync stage, read by s2 only
  logic       s2_reg;    // second sync stage
  logic       filt_reg;  // filtered level
  logic [2:0] cnt_reg;   // agreeing samples so far
  logic       use_sync;  // path decision

  // synchroniser always runs so the pin never feeds logic raw
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
    end else begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
    end
  end

  // filter: follow only after FILT_LEN differing samples in a row
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg  <= 3'h0;
      filt_reg <= 1'b0;
    end else if (run) begin
      if (s2_reg == filt_reg) begin
        cnt_reg <= 3'h0;  // glitch over, start again
      end else if (cnt_reg == FILT_LEN - 3'h1) begin
        filt_reg <= s2_reg;
        cnt_reg  <= 3'h0;
      end else begin
        cnt_reg <= cnt_reg + 3'h1;
      end
    end
  end

  // both selects clear falls back to the safe sync-only path
  assign use_sync = sel_sync | ~sel_filt;

  // output stage, frozen while the encoder clock is off
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cond_out <= 1'b0;
    end else if (run) begin
      cond_out <= use_sync ? s2_reg : filt_reg;
    end
  end

endmodule : qig_in_cond

`default_nettype wire

// File: rtl/qig_top.sv
// Function
// - bit 9 stops encoder clock domain
// - encoder clock runs after reset
// - encoder flags phase error on A/B
// - both phase errors feed select mux
// - mux output inverted toward timer
// - inputs pass sync or sync+filter
// - phase A path bits 0 and 1
// - phase B path bits 8 and 9
// - index path bits 16 and 17
// - strobe path bits 24 and 25
`timescale 1ns/1ps
`default_nettype none

module qig_top
  import qig_pkg::*;
(
  input  wire logic        CLK_SYS,
  input  wire logic        RST_N,
  input  wire logic [4:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output var  logic [31:0] AVS_READDATA,
  output var  logic        AVS_WAITREQUEST,
  input  wire logic [1:0]  PHASE_A_PIN,
  input  wire logic [1:0]  PHASE_B_PIN,
  input  wire logic [1:0]  INDEX_PIN,
  input  wire logic [1:0]  STROBE_PIN,
  output wire logic [1:0]  QUAD_PHASE_A_IN,
  output wire logic [1:0]  QUAD_PHASE_B_IN,
  output wire logic [1:0]  QUAD_INDEX_IN,
  output wire logic [1:0]  QUAD_STROBE_IN,
  output var  logic        ENC_CLK_EN,
  output var  logic [1:0]  PHASE_ERROR_OUT,
  output var  logic        HET_PHASE_ERR_N,
  output var  logic        IRQ
);
  import qig_pkg::*;

  // software registers
  logic [31:0] clock_domain_disable_reg;  // only the encoder bit kept
  logic [31:0] input_path_select_reg;     // one lane per input kind
  logic        mux_sel_reg;               // phase error source
  logic [1:0]  status_reg;                // sticky phase error events
  logic [1:0]  mask_reg;                  // interrupt enables
  logic [1:0]  status_next;

  // bus handshake
  logic        waitreq_reg;   // low for exactly the answer cycle
  logic [31:0] rdata_reg;     // captured read word
  logic [4:0]  addr_word;     // word-aligned address
  logic        rd_take;       // first cycle of a read
  logic        rd_done;       // completing edge of a read
  logic        wr_hit;        // completing edge of a write
  logic [31:0] rd_mux;        // read data before capture

  // encoder side
  logic [7:0]  pin_bus;       // enc*4 + input kind
  logic [7:0]  cond_bus;      // conditioned levels
  logic [3:0]  sel_sync_w;    // per kind, sync-only bit
  logic [3:0]  sel_filt_w;    // per kind, filter bit
  logic [1:0]  prev_a_reg;    // last A seen while running
  logic [1:0]  prev_b_reg;    // last B seen while running
  logic [1:0]  err_now;       // phase error this cycle
  logic        sel_err;       // mux output before inversion
  logic        wrote_cdd_reg; // helper: software touched the gate

  // byte-lane merge, shared by the gate and path select registers
  function automatic logic [31:0] be_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  be,
    input logic [31:0] wmask
  );
    logic [31:0] m;
    m = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return m & wmask;
  endfunction : be_merge

  assign addr_word = {AVS_ADDRESS[4:2], 2'b00};
  assign rd_take   = AVS_READ & waitreq_reg;
  assign rd_done   = AVS_READ & ~waitreq_reg;
  assign wr_hit    = AVS_WRITE & ~waitreq_reg;

  // one wait cycle per access; the master holds the request meanwhile
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      waitreq_reg <= 1'b1;
    end else begin
      waitreq_reg <= ~((AVS_READ | AVS_WRITE) & waitreq_reg);
    end
  end

  // read decode; unmapped words read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (addr_word)
      OFS_CDD:  rd_mux = clock_domain_disable_reg;
      OFS_PATH: rd_mux = input_path_select_reg;
      OFS_MUX:  rd_mux[MUX_SEL_BIT] = mux_sel_reg;
      OFS_STAT: rd_mux[1:0] = status_reg;
      OFS_MASK: rd_mux[1:0] = mask_reg;
      OFS_LIVE: begin
        rd_mux[LIVE_ERR_OFS +: 2] = PHASE_ERROR_OUT;
        rd_mux[LIVE_IN_OFS +: 8]  = cond_bus;
        rd_mux[LIVE_CLK_BIT]      = ENC_CLK_EN;
      end
      default:  rd_mux = 32'h0000_0000;
    endcase
  end

  // read word captured early so it stands through the answer cycle
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rdata_reg <= 32'h0000_0000;
    end else if (rd_take) begin
      rdata_reg <= rd_mux;
    end
  end

  assign AVS_READDATA    = rdata_reg;
  assign AVS_WAITREQUEST = waitreq_reg;

  // control registers written on the completing edge only
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      clock_domain_disable_reg <= RST_CDD;
      input_path_select_reg    <= RST_PATH;
      mux_sel_reg              <= RST_MUX;
      mask_reg                 <= RST_MASK;
    end else if (wr_hit) begin
      case (addr_word)
        OFS_CDD: begin
          clock_domain_disable_reg <= be_merge(clock_domain_disable_reg,
            AVS_WRITEDATA, AVS_BYTEENABLE, CDD_WMASK);
        end
        OFS_PATH: begin
          input_path_select_reg <= be_merge(input_path_select_reg,
            AVS_WRITEDATA, AVS_BYTEENABLE, PATH_WMASK);
        end
        OFS_MUX: begin
          if (AVS_BYTEENABLE[0]) begin
            mux_sel_reg <= AVS_WRITEDATA[MUX_SEL_BIT];
          end
        end
        OFS_MASK: begin
          if (AVS_BYTEENABLE[0]) begin
            mask_reg <= AVS_WRITEDATA[1:0];
          end
        end
        default: begin
          // read-only or unmapped: write dropped
        end
      endcase
    end
  end

  // gate register drives the encoder domain run flag; reset leaves it on
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ENC_CLK_EN <= 1'b1;
    end else begin
      ENC_CLK_EN <= ~clock_domain_disable_reg[CDD_ENC_BIT];
    end
  end

  // path select bits for each input kind, shared by both encoders
  for (genvar k = 0; k < NUM_IN; k++) begin : g_sel
    // lanes 0, 8, 16, 24 for a, b, index, strobe
    assign sel_sync_w[k] =
      input_path_select_reg[PATH_LANE_W*k + PATH_SYNC_OFS];
    assign sel_filt_w[k] =
      input_path_select_reg[PATH_LANE_W*k + PATH_FILT_OFS];
  end

  // pack pins as enc*4 + kind
  assign pin_bus = {STROBE_PIN[1], INDEX_PIN[1], PHASE_B_PIN[1], PHASE_A_PIN[1],
                    STROBE_PIN[0], INDEX_PIN[0], PHASE_B_PIN[0], PHASE_A_PIN[0]};

  // one conditioner per pin; gating freezes their filter and output stage via run
  for (genvar e = 0; e < NUM_ENC; e++) begin : g_enc
    for (genvar k = 0; k < NUM_IN; k++) begin : g_in
      qig_in_cond u_cond (
        .clk_sys  (CLK_SYS),
        .rst_n    (RST_N),
        .pin      (pin_bus[e*NUM_IN + k]),
        .run      (ENC_CLK_EN),
        .sel_sync (sel_sync_w[k]),
        .sel_filt (sel_filt_w[k]),
        .cond_out (cond_bus[e*NUM_IN + k])
      );
    end
  end

  assign QUAD_PHASE_A_IN = {cond_bus[4], cond_bus[0]};
  assign QUAD_PHASE_B_IN = {cond_bus[5], cond_bus[1]};
  assign QUAD_INDEX_IN   = {cond_bus[6], cond_bus[2]};
  assign QUAD_STROBE_IN  = {cond_bus[7], cond_bus[3]};

  // a and b flipping in the same sample is an illegal quadrature step
  assign err_now = {2{ENC_CLK_EN}} &
                   (QUAD_PHASE_A_IN ^ prev_a_reg) &
                   (QUAD_PHASE_B_IN ^ prev_b_reg);

  // phase history held while the clock is off; the error pulse is forced low then
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      prev_a_reg      <= 2'h0;
      prev_b_reg      <= 2'h0;
      PHASE_ERROR_OUT <= 2'h0;
    end else begin
      PHASE_ERROR_OUT <= err_now;
      if (ENC_CLK_EN) begin
        prev_a_reg <= QUAD_PHASE_A_IN;
        prev_b_reg <= QUAD_PHASE_B_IN;
      end
    end
  end

  // selection mux, then inverted: an error shows low at the timer
  assign sel_err = mux_sel_reg ? PHASE_ERROR_OUT[1] : PHASE_ERROR_OUT[0];

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      HET_PHASE_ERR_N <= 1'b1;
    end else begin
      HET_PHASE_ERR_N <= ~sel_err;
    end
  end

  // sticky status; clear only what the read returned, new events win
  always_comb begin
    status_next = status_reg;
    if (rd_done && (addr_word == OFS_STAT)) begin
      status_next = status_next & ~rdata_reg[1:0];
    end
    status_next = status_next | PHASE_ERROR_OUT;
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      status_reg <= 2'h0;
    end else begin
      status_reg <= status_next;
    end
  end

  // level interrupt, one cycle behind the status bits
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(status_reg & mask_reg);
    end
  end

  // helper for checks: has software written the gate register yet
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      wrote_cdd_reg <= 1'b0;
    end else if (wr_hit && (addr_word == OFS_CDD)) begin
      wrote_cdd_reg <= 1'b1;
    end
  end

  // checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  gate_stop_a: assert property (
    clock_domain_disable_reg[CDD_ENC_BIT] |=> !ENC_CLK_EN)
    else $error("encoder clock not stopped");

  gate_hold_a: assert property (
    !ENC_CLK_EN |=> $stable(cond_bus) && (PHASE_ERROR_OUT == 2'h0))
    else $error("encoder logic moved while gated");

  boot_run_a: assert property (
    !wrote_cdd_reg |-> ENC_CLK_EN)
    else $error("encoder clock off before any write");

  perr_set_a: assert property (
    ENC_CLK_EN && $past(ENC_CLK_EN) && $changed(QUAD_PHASE_A_IN[0])
      && $changed(QUAD_PHASE_B_IN[0]) |=> PHASE_ERROR_OUT[0])
    else $error("phase error missed");

  perr_quiet_a: assert property (
    $past(ENC_CLK_EN) && $stable(QUAD_PHASE_A_IN[1]) |=> !PHASE_ERROR_OUT[1])
    else $error("false phase error");

  het_path_a: assert property (
    PHASE_ERROR_OUT[1] && mux_sel_reg |=> !HET_PHASE_ERR_N)
    else $error("selected error not forwarded");

  het_idle_a: assert property (
    (PHASE_ERROR_OUT == 2'h0) |=> HET_PHASE_ERR_N)
    else $error("timer error low without cause");

  sync_pa_a: assert property (
    (sel_sync_w[0] && ENC_CLK_EN)[*3] |=>
      QUAD_PHASE_A_IN[0] == $past(PHASE_A_PIN[0], 3))
    else $error("phase a sync path wrong");

  sync_pb_a: assert property (
    (sel_sync_w[1] && ENC_CLK_EN)[*3] |=>
      QUAD_PHASE_B_IN[1] == $past(PHASE_B_PIN[1], 3))
    else $error("phase b sync path wrong");

  sync_idx_a: assert property (
    (sel_sync_w[2] && ENC_CLK_EN)[*3] |=>
      QUAD_INDEX_IN[0] == $past(INDEX_PIN[0], 3))
    else $error("index sync path wrong");

  sync_stb_a: assert property (
    (sel_sync_w[3] && ENC_CLK_EN)[*3] |=>
      QUAD_STROBE_IN[1] == $past(STROBE_PIN[1], 3))
    else $error("strobe sync path wrong");

  filt_settle_a: assert property (
    (!sel_sync_w[0] && sel_filt_w[0] && ENC_CLK_EN
      && $stable(PHASE_A_PIN[0]))[*8] |=>
      QUAD_PHASE_A_IN[0] == $past(PHASE_A_PIN[0]))
    else $error("filtered path did not settle");

  path_dflt_a: assert property (
    (!sel_sync_w[0] && !sel_filt_w[0] && ENC_CLK_EN)[*3] |=>
      QUAD_PHASE_A_IN[1] == $past(PHASE_A_PIN[1], 3))
    else $error("undefined path not sync-only");

  irq_mask_a: assert property (
    |(status_reg & mask_reg) |=> IRQ)
    else $error("unmasked event without interrupt");

  perr_seen_c: cover property (PHASE_ERROR_OUT[0] ##1 !HET_PHASE_ERR_N);
  gated_c:     cover property (ENC_CLK_EN ##1 !ENC_CLK_EN ##[1:100] ENC_CLK_EN);
  irq_c:       cover property ($rose(IRQ) ##[1:20] rd_done);
  glitch_c:    cover property (!sel_sync_w[0] && sel_filt_w[0]
                  && $rose(PHASE_A_PIN[0]) ##1 $fell(PHASE_A_PIN[0]));

endmodule : qig_top

`default_nettype wire

// File: bench/qig_enc_model.sv
`timescale 1ns/1ps
`default_nettype none

// external quadrature encoder pair: drives phase a, b, index, strobe
module qig_enc_model (
  input  wire logic       clk,          // peripheral clock, for pacing only
  output wire logic [1:0] phase_a_pin,  // bit e = encoder e
  output wire logic [1:0] phase_b_pin,
  output wire logic [1:0] index_pin,
  output wire logic [1:0] strobe_pin
);
  // pin levels, index kind*2+enc; push-pull pins, always driven
  logic [7:0] st = 8'h00;

  assign {strobe_pin, index_pin, phase_b_pin, phase_a_pin} = st;

  // toggle the pins in m just after an edge; w > 0 gives a w-cycle pulse
  // a mask with both a and b of one encoder models a skipped quadrature state
  task automatic drive(input logic [7:0] m, input int w);
    @(posedge clk);
    st <= st ^ m;
    if (w > 0) begin
      repeat (w) @(posedge clk);
      st <= st ^ m;
    end
  endtask : drive
endmodule : qig_enc_model

`default_nettype wire

// File: bench/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
  import qig_pkg::*;

  logic        clk_sys, rst_n, avs_read, avs_write;  // bench-driven
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable;
  logic        avs_waitrequest, enc_clk_en, het_n, irq;
  logic [1:0]  pa, pb, pi, ps, qa, qb, qi, qs, pe;
  int          n_errors  = 0;                        // mismatches
  int          tests_run = 0;                        // comparisons
  int          cyc       = 0;                        // timeout counter
  int          pe_cnt[2] = '{0, 0};                  // phase error pulses
  int          het_cnt   = 0;                        // timer-side low cycles
  logic [31:0] seed      = 32'h0001_30fa;            // xorshift state
  wire  [7:0]  quad      = {qs, qi, qb, qa};         // kind*2+enc

  qig_top u_dut (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
    .PHASE_A_PIN(pa), .PHASE_B_PIN(pb), .INDEX_PIN(pi), .STROBE_PIN(ps),
    .QUAD_PHASE_A_IN(qa), .QUAD_PHASE_B_IN(qb), .QUAD_INDEX_IN(qi), .QUAD_STROBE_IN(qs),
    .ENC_CLK_EN(enc_clk_en), .PHASE_ERROR_OUT(pe), .HET_PHASE_ERR_N(het_n), .IRQ(irq)
  );

  qig_enc_model u_enc (
    .clk(clk_sys), .phase_a_pin(pa), .phase_b_pin(pb), .index_pin(pi), .strobe_pin(ps)
  );

  // 200 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // pulse counters; outputs are one-cycle pulses, so count every edge
  always @(posedge clk_sys) begin
    if (rst_n) begin
      pe_cnt[0] += int'(pe[0]);
      pe_cnt[1] += int'(pe[1]);
      het_cnt   += int'(!het_n);
    end
  end

  // hang guard, well above the roughly 1300 cycles the run needs
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      wrap_up();
    end
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // filtered path expected for input kind k: sync bit clear, filter bit set
  function automatic logic exp_filt(input logic [31:0] p, input int k);
    return p[k * PATH_LANE_W + PATH_FILT_OFS] & ~p[k * PATH_LANE_W + PATH_SYNC_OFS];
  endfunction : exp_filt

  // avalon write: hold everything until waitrequest is sampled low
  // no local limit; a slave that never answers is caught by the hang guard
  task automatic bus_wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk_sys);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_write      <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask : bus_wr

  // avalon read: data taken at the edge where waitrequest is low
  task automatic bus_rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_read    <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask : bus_rd

  // single exit point
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  initial begin
    logic [31:0] d, path, msk;
    logic        f, old;
    logic [7:0]  q;
    int          pc, po, h;
    rst_n          = 1'b0;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_address    = 5'h00;
    avs_writedata  = 32'h0000_0000;
    avs_byteenable = 4'h0;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    // reset state and register map corners
    #1 chk(enc_clk_en, 1'b1);
    chk(het_n, 1'b1);
    bus_rd(OFS_CDD, d);
    chk(d, RST_CDD);
    bus_rd(OFS_PATH, d);
    chk(d, RST_PATH);
    bus_rd(OFS_LIVE, d);
    chk(d, 32'h0000_0400);
    bus_rd(5'h18, d);  // unmapped reads zero
    chk(d, 32'h0000_0000);
    bus_wr(OFS_LIVE, 32'hffff_ffff, 4'hf);  // read-only, ignored
    bus_wr(OFS_PATH, 32'hffff_ffff, 4'hf);
    bus_rd(OFS_PATH, d);
    chk(d, PATH_WMASK);
    $display("test regs done");
    // path select: corners first (all clear, filter only, both set), then random
    for (int r = 0; r < 5; r++) begin
      path = (r == 0) ? 32'h0000_0000 : (r == 1) ? 32'h0202_0202 :
             (r == 2) ? PATH_WMASK : (xs() & PATH_WMASK);
      bus_wr(OFS_PATH, path, 4'hf);
      for (int b = 0; b < 8; b++) begin
        f   = exp_filt(path, b / 2);
        old = quad[b];
        // one-cycle glitch passes the sync path, the filter swallows it
        u_enc.drive(8'h01 << b, 1);
        repeat (2) @(posedge clk_sys);
        #1 chk(quad[b], old ^ !f);
        repeat (10) @(posedge clk_sys);
        u_enc.drive(8'h01 << b, 0);
        repeat (12) @(posedge clk_sys);
        #1 chk(quad[b], !old);
      end
    end
    $display("test paths done");
    // phase error per encoder, both mux settings, random mask
    bus_wr(OFS_PATH, RST_PATH, 4'hf);
    for (int m = 0; m < 2; m++) begin
      for (int e = 0; e < 2; e++) begin
        msk = xs() & 32'h0000_0003;
        bus_wr(OFS_MUX, m, 4'h1);
        bus_wr(OFS_MASK, msk, 4'h1);
        bus_rd(OFS_STAT, d);
        pc = pe_cnt[e];
        po = pe_cnt[1 - e];
        h  = het_cnt;
        u_enc.drive(8'h05 << e, 0);
        repeat (10) @(posedge clk_sys);
        #1 chk(pe_cnt[e] - pc, 1);
        chk(pe_cnt[1 - e] - po, 0);
        chk(het_cnt - h, (e == m));
        chk(irq, msk[e]);
        bus_rd(OFS_STAT, d);
        chk(d, 32'h1 << e);
        @(posedge clk_sys);
        #1 chk(irq, 1'b0);
      end
    end
    $display("test phase error done");
    // encoder clock gating; the wrong byte lane must not stop it
    bus_wr(OFS_CDD, 32'h0000_0200, 4'hd);
    repeat (2) @(posedge clk_sys);
    #1 chk(enc_clk_en, 1'b1);
    bus_wr(OFS_CDD, 32'h0000_0200, 4'h2);
    repeat (2) @(posedge clk_sys);
    #1 chk(enc_clk_en, 1'b0);
    q  = quad;
    pc = pe_cnt[1];
    u_enc.drive(8'h0a, 0);
    repeat (10) @(posedge clk_sys);
    #1 chk(quad, q);
    chk(pe_cnt[1] - pc, 0);
    bus_rd(OFS_LIVE, d);
    chk(d[10], 1'b0);
    bus_wr(OFS_CDD, 32'h0000_0000, 4'hf);
    repeat (10) @(posedge clk_sys);
    #1 chk(enc_clk_en, 1'b1);
    chk(quad, q ^ 8'h0a);
    $display("test gating done");
    wrap_up();
  end
endmodule : tb

`default_nettype wire
